// ### hw/asp_top.sv
// Async serial port with fractional bit-rate generator, FIFOs and infrared codec
module asp_top
    import asp_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
)
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_ctl_write,
    input wire asp_ctl_type i_ctl,
    output asp_ctl_type o_ctl,
    input wire logic i_div_int_write,
    input wire logic [DIV_INT_W-1:0] i_div_int,
    input wire logic i_div_frac_write,
    input wire logic [DIV_FRAC_W-1:0] i_div_frac,
    input wire logic i_lcr_write,
    input wire asp_lcr_type i_lcr,
    output asp_line_cfg_type o_line_cfg,
    input wire logic [7:0] i_ir_lp_divisor,
    input wire logic i_tx_write,
    input wire logic [DATA_W-1:0] i_tx_data,
    output logic o_tx_full,
    output logic o_tx_empty,
    output logic o_busy,
    input wire logic i_rx_pop,
    output asp_rx_entry_type o_rx_entry,
    output logic o_rx_valid,
    output logic o_rx_full,
    output logic o_rx_timeout,
    input wire logic i_serial_in,
    output logic o_serial_out
);

    asp_ctl_type ctl_q;
    logic [DIV_INT_W-1:0] div_int_q;
    logic [DIV_FRAC_W-1:0] div_frac_q;
    asp_line_cfg_type cfg_q;

    logic [DIV_INT_W-1:0] baud_cnt_q;
    logic [DIV_FRAC_W-1:0] frac_acc_q;
    logic extra_q;
    logic [DIV_FRAC_W:0] frac_sum;
    logic tick16;
    logic [7:0] lp_cnt_q;
    logic lp_tick;

    logic [DATA_W-1:0] tx_fifo_data;
    logic tx_empty;
    logic tx_load;
    logic tx_bit_end;
    logic tx_frame_end;
    logic tx_bit_start;
    asp_frame_state_type tx_state_q;
    logic [3:0] tx_phase_q;
    logic [2:0] tx_bit_q;
    logic [DATA_W-1:0] tx_shift_q;
    logic tx_bit_d;
    logic tx_line_q;
    logic bit_start_q;
    logic [1:0] lp_pulse_q;
    logic ser_out_d;
    logic ser_out_q;

    logic rx_meta_q;
    logic rx_sync_q;
    logic [4:0] ir_hold_q;
    logic rx_line;
    logic rx_prev_q;
    asp_frame_state_type rx_state_q;
    logic [3:0] rx_phase_q;
    logic [2:0] rx_bit_q;
    logic rx_sample;
    logic [DATA_W-1:0] rx_data_q;
    logic rx_zero_q;
    logic rx_par_err_q;
    logic rx_push;
    logic rx_empty;
    logic overrun_pend_q;
    logic [9:0] rx_idle_q;
    asp_rx_entry_type rx_entry;

    assign o_ctl = ctl_q;
    assign o_line_cfg = cfg_q;

    // Control and configuration registers
    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            ctl_q <= CTL_RESET;
            div_int_q <= DIV_INT_RESET;
            div_frac_q <= DIV_FRAC_RESET;
            cfg_q <= {DIV_INT_RESET, DIV_FRAC_RESET, LCR_RESET};
        end
        else
        begin
            if (i_ctl_write)
            begin
                ctl_q <= i_ctl;
            end
            if (i_div_int_write)
            begin
                div_int_q <= i_div_int;
            end
            if (i_div_frac_write)
            begin
                div_frac_q <= i_div_frac;
            end
            // Divisor writes stay invisible to the generator until this load
            if (i_lcr_write)
            begin
                cfg_q <= {div_int_q, div_frac_q, i_lcr};
            end
        end
    end

    // Fractional 16x generator: a carry out of the fraction stretches one period
    assign frac_sum = {1'b0, frac_acc_q} + {1'b0, cfg_q.div_frac};
    assign tick16 = (cfg_q.div_int != '0) &&
        ({1'b0, baud_cnt_q} + 17'h1 >= {1'b0, cfg_q.div_int} + {16'h0, extra_q});

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            baud_cnt_q <= '0;
            frac_acc_q <= '0;
            extra_q <= 1'b0;
        end
        else if (tick16)
        begin
            baud_cnt_q <= '0;
            {extra_q, frac_acc_q} <= frac_sum;
        end
        else
        begin
            baud_cnt_q <= baud_cnt_q + 16'h1;
        end
    end

    // Low-power infrared tick; divisor 0 gives 256 through wrap-around
    assign lp_tick = (lp_cnt_q == i_ir_lp_divisor - 8'h1);

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            lp_cnt_q <= '0;
        end
        else if (lp_tick || bit_start_q)
        begin
            lp_cnt_q <= '0;
        end
        else
        begin
            lp_cnt_q <= lp_cnt_q + 8'h1;
        end
    end

    asp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH_P)
    ) u_tx_fifo (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_deep(cfg_q.lcr.fifo_enable),
        .i_push(i_tx_write),
        .i_data(i_tx_data),
        .i_pop(tx_load),
        .o_data(tx_fifo_data),
        .o_full(o_tx_full),
        .o_empty(tx_empty)
    );

    assign o_tx_empty = tx_empty;
    assign o_busy = !tx_empty || (tx_state_q != ST_IDLE);

    // Enables gate only the start of a frame, never a frame under way
    assign tx_bit_end = tick16 && (tx_phase_q == PHASE_LAST);
    assign tx_frame_end = (tx_state_q == ST_STOP) && tx_bit_end &&
        (!cfg_q.lcr.two_stop || tx_bit_q[0]);
    assign tx_load = tick16 && ctl_q.port_enable && ctl_q.tx_enable && !tx_empty &&
        ((tx_state_q == ST_IDLE) || tx_frame_end);
    assign tx_bit_start = tx_load || (tx_bit_end && (tx_state_q != ST_IDLE) && !tx_frame_end);

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            tx_state_q <= ST_IDLE;
            tx_bit_q <= '0;
            tx_shift_q <= '0;
        end
        else if (tx_load)
        begin
            tx_state_q <= ST_START;
            tx_shift_q <= tx_fifo_data;
        end
        else if (tx_bit_end)
        begin
            case (tx_state_q)
                ST_START:
                begin
                    tx_state_q <= ST_DATA;
                    tx_bit_q <= '0;
                end
                ST_DATA:
                begin
                    if (tx_bit_q == asp_last_bit(cfg_q.lcr))
                    begin
                        tx_state_q <= cfg_q.lcr.parity_enable ? ST_PARITY : ST_STOP;
                        tx_bit_q <= '0;
                    end
                    else
                    begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                    end
                end
                ST_PARITY:
                begin
                    tx_state_q <= ST_STOP;
                    tx_bit_q <= '0;
                end
                ST_STOP:
                begin
                    if (tx_frame_end)
                    begin
                        tx_state_q <= ST_IDLE;
                    end
                    else
                    begin
                        tx_bit_q <= 3'h1;
                    end
                end
                default:
                begin
                    tx_state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            tx_phase_q <= '0;
        end
        else if (tx_load)
        begin
            tx_phase_q <= '0;
        end
        else if (tick16)
        begin
            tx_phase_q <= tx_phase_q + 4'h1;
        end
    end

    always_comb
    begin
        case (tx_state_q)
            ST_START: tx_bit_d = 1'b0;
            ST_DATA: tx_bit_d = tx_shift_q[tx_bit_q];
            ST_PARITY: tx_bit_d = asp_parity(tx_shift_q, cfg_q.lcr);
            default: tx_bit_d = 1'b1;
        endcase
        if (cfg_q.lcr.send_break)
        begin
            tx_bit_d = 1'b0;
        end
    end

    // Infrared encoder; every bit start restarts the low-power divider
    always_comb
    begin
        if (!ctl_q.ir_enable)
        begin
            ser_out_d = tx_bit_d;
        end
        else if (ctl_q.ir_lowpower)
        begin
            ser_out_d = (lp_pulse_q != '0);
        end
        else
        begin
            ser_out_d = !tx_bit_d && (tx_phase_q < IR_NORMAL_PHASES);
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            bit_start_q <= 1'b0;
            lp_pulse_q <= '0;
            tx_line_q <= 1'b1;
            ser_out_q <= 1'b1;
        end
        else
        begin
            bit_start_q <= tx_bit_start;
            tx_line_q <= tx_bit_d;
            ser_out_q <= ser_out_d;
            if (bit_start_q && !tx_bit_d)
            begin
                lp_pulse_q <= IR_LP_PULSE_TICKS;
            end
            else if (lp_tick && (lp_pulse_q != '0))
            begin
                lp_pulse_q <= lp_pulse_q - 2'h1;
            end
        end
    end

    assign o_serial_out = ser_out_q;

    // Receive input: synchroniser, infrared decoder stretches low pulses one bit
    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            ir_hold_q <= '0;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= i_serial_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_line;
            if (!rx_sync_q)
            begin
                ir_hold_q <= IR_RX_HOLD_TICKS;
            end
            else if (tick16 && (ir_hold_q != '0))
            begin
                ir_hold_q <= ir_hold_q - 5'h1;
            end
        end
    end

    assign rx_line = ctl_q.loopback ? tx_line_q :
        (ctl_q.ir_enable ? (ir_hold_q == '0) : rx_sync_q);
    assign rx_sample = tick16 && (rx_phase_q == PHASE_LAST);
    assign rx_push = (rx_state_q == ST_STOP) && rx_sample;

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            rx_state_q <= ST_IDLE;
            rx_phase_q <= '0;
            rx_bit_q <= '0;
        end
        else
        begin
            case (rx_state_q)
                ST_IDLE:
                begin
                    rx_phase_q <= '0;
                    if (rx_prev_q && !rx_line && ctl_q.port_enable && ctl_q.rx_enable)
                    begin
                        rx_state_q <= ST_START;
                    end
                end
                ST_START:
                begin
                    if (tick16 && (rx_phase_q == START_CHECK_PHASE))
                    begin
                        rx_state_q <= rx_line ? ST_IDLE : ST_DATA;
                        rx_phase_q <= '0;
                        rx_bit_q <= '0;
                    end
                    else if (tick16)
                    begin
                        rx_phase_q <= rx_phase_q + 4'h1;
                    end
                end
                default:
                begin
                    if (tick16)
                    begin
                        rx_phase_q <= rx_phase_q + 4'h1;
                    end
                    if (rx_sample)
                    begin
                        if (rx_state_q == ST_DATA)
                        begin
                            rx_bit_q <= rx_bit_q + 3'h1;
                            if (rx_bit_q == asp_last_bit(cfg_q.lcr))
                            begin
                                rx_state_q <= cfg_q.lcr.parity_enable ? ST_PARITY : ST_STOP;
                            end
                        end
                        else if (rx_state_q == ST_PARITY)
                        begin
                            rx_state_q <= ST_STOP;
                        end
                        else
                        begin
                            rx_state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            rx_data_q <= '0;
            rx_zero_q <= 1'b0;
            rx_par_err_q <= 1'b0;
        end
        else if (rx_state_q == ST_START)
        begin
            rx_data_q <= '0;
            rx_zero_q <= 1'b1;
            rx_par_err_q <= 1'b0;
        end
        else if (rx_sample && (rx_state_q == ST_DATA))
        begin
            rx_data_q[rx_bit_q] <= rx_line;
            rx_zero_q <= rx_zero_q && !rx_line;
        end
        else if (rx_sample && (rx_state_q == ST_PARITY))
        begin
            rx_par_err_q <= (rx_line != asp_parity(rx_data_q, cfg_q.lcr));
            rx_zero_q <= rx_zero_q && !rx_line;
        end
    end

    // A dropped character marks the next stored one with overrun
    always_comb
    begin
        rx_entry.data = rx_data_q;
        rx_entry.frame_err = !rx_line;
        rx_entry.parity_err = rx_par_err_q;
        rx_entry.line_break = rx_zero_q && !rx_line;
        rx_entry.overrun = overrun_pend_q;
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            overrun_pend_q <= 1'b0;
        end
        else if (rx_push && o_rx_full)
        begin
            overrun_pend_q <= 1'b1;
        end
        else if (rx_push)
        begin
            overrun_pend_q <= 1'b0;
        end
    end

    asp_fifo #(
        .WIDTH($bits(asp_rx_entry_type)),
        .DEPTH(FIFO_DEPTH_P)
    ) u_rx_fifo (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_deep(cfg_q.lcr.fifo_enable),
        .i_push(rx_push),
        .i_data(rx_entry),
        .i_pop(i_rx_pop),
        .o_data(o_rx_entry),
        .o_full(o_rx_full),
        .o_empty(rx_empty)
    );

    assign o_rx_valid = !rx_empty;

    // Idle counter runs only while characters wait and the line is quiet
    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            rx_idle_q <= '0;
        end
        else if (rx_push || rx_empty || (rx_state_q != ST_IDLE))
        begin
            rx_idle_q <= '0;
        end
        else if (tick16 && (rx_idle_q != RX_TIMEOUT_TICKS))
        begin
            rx_idle_q <= rx_idle_q + 10'h1;
        end
    end

    assign o_rx_timeout = (rx_idle_q == RX_TIMEOUT_TICKS);

endmodule

// ### hw/asp_pkg.sv
// Shared types, constants and helper functions for the async serial port
package asp_pkg;

    localparam int DIV_INT_W = 16;
    localparam int DIV_FRAC_W = 6;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // Reference ticks within one bit period; IR_LP_PULSE_TICKS counts low-power ticks
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] START_CHECK_PHASE = 4'h7;
    localparam logic [3:0] IR_NORMAL_PHASES = 4'h3;
    localparam logic [1:0] IR_LP_PULSE_TICKS = 2'h3;
    localparam logic [4:0] IR_RX_HOLD_TICKS = 5'h10;

    // Receive timeout: 32 bit periods of 16 reference ticks
    localparam int RX_TIMEOUT_BITS = 32;
    localparam logic [9:0] RX_TIMEOUT_TICKS = 10'(RX_TIMEOUT_BITS * 16);

    typedef struct packed {
        logic rx_enable;
        logic tx_enable;
        logic loopback;
        logic ir_lowpower;
        logic ir_enable;
        logic port_enable;
    } asp_ctl_type;

    typedef struct packed {
        logic stick_parity;
        logic [1:0] word_len;
        logic fifo_enable;
        logic two_stop;
        logic even_parity;
        logic parity_enable;
        logic send_break;
    } asp_lcr_type;

    // Divisor and line control held together, loaded as one word
    typedef struct packed {
        logic [DIV_INT_W-1:0] div_int;
        logic [DIV_FRAC_W-1:0] div_frac;
        asp_lcr_type lcr;
    } asp_line_cfg_type;

    typedef struct packed {
        logic overrun;
        logic line_break;
        logic parity_err;
        logic frame_err;
        logic [DATA_W-1:0] data;
    } asp_rx_entry_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_DATA = 3'h3,
        ST_PARITY = 3'h2,
        ST_STOP = 3'h6
    } asp_frame_state_type;

    localparam asp_ctl_type CTL_RESET = 6'h30;
    localparam asp_lcr_type LCR_RESET = 8'h00;
    localparam logic [DIV_INT_W-1:0] DIV_INT_RESET = 16'h0000;
    localparam logic [DIV_FRAC_W-1:0] DIV_FRAC_RESET = 6'h00;

    // Parity bit for the data bits in use
    function automatic logic asp_parity(input logic [7:0] data, input asp_lcr_type lcr);
        logic [7:0] mask;
        mask = 8'hff >> (2'h3 - lcr.word_len);
        if (lcr.stick_parity)
        begin
            return !lcr.even_parity;
        end
        return (^(data & mask)) ^ !lcr.even_parity;
    endfunction

    // Index of the last data bit: 4 to 7
    function automatic logic [2:0] asp_last_bit(input asp_lcr_type lcr);
        return {1'b1, lcr.word_len};
    endfunction

endpackage

// ### hw/asp_fifo.sv
// Flip-flop FIFO with single-entry or full-depth capacity
module asp_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_deep,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_data,
    output logic o_full,
    output logic o_empty
);
    // Pointers wrap naturally, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic do_push;
    logic do_pop;

    assign o_empty = (count_q == '0);
    assign o_full = i_deep ? (count_q == CW'(DEPTH)) : !o_empty;
    assign do_push = i_push && !o_full;
    assign do_pop = i_pop && !o_empty;
    assign o_data = mem_q[rd_q];

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else if (do_push)
        begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_q <= wr_q + AW'(1);
            end
            if (do_pop)
            begin
                rd_q <= rd_q + AW'(1);
            end
            count_q <= count_q + CW'(do_push) - CW'(do_pop);
        end
    end

endmodule

// ### tb/asp_checker.sv
// Checker on the serial port's top-level ports
module asp_checker
    import asp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire asp_ctl_type o_ctl,
    input wire logic i_lcr_write,
    input wire asp_lcr_type i_lcr,
    input wire asp_line_cfg_type o_line_cfg,
    input wire logic i_tx_write,
    input wire logic o_tx_full,
    input wire logic o_tx_empty,
    input wire logic o_busy,
    input wire logic o_rx_valid,
    input wire logic o_rx_timeout,
    input wire logic o_serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    AST_RESET_CTL: assert property ($fell(i_reset) |-> o_ctl == CTL_RESET)
        else $error("bad reset control");
    AST_BUSY_SET: assert property (i_tx_write && !o_tx_full |=> o_busy && !o_tx_empty)
        else $error("busy not set");
    AST_BUSY_HOLD: assert property (!o_tx_empty |-> o_busy)
        else $error("busy low with data");
    AST_CFG_LOAD: assert property (i_lcr_write |=> o_line_cfg.lcr == $past(i_lcr))
        else $error("line config not loaded");
    AST_CFG_HOLD: assert property (!i_lcr_write |=> $stable(o_line_cfg))
        else $error("line config moved");
    // Three quiet cycles cover the output register's lag
    AST_IDLE_HIGH: assert property ((!o_busy && !o_ctl.ir_enable && !o_line_cfg.lcr.send_break) [*3]
        |-> o_serial_out)
        else $error("idle line low");
    AST_TIMEOUT_EMPTY: assert property (!o_rx_valid [*2] |-> !o_rx_timeout)
        else $error("timeout while empty");
    AST_SINGLE_FULL: assert property (!o_line_cfg.lcr.fifo_enable && !o_tx_empty |-> o_tx_full)
        else $error("single entry not full");
    C_FULL: cover property (o_tx_full && o_line_cfg.lcr.fifo_enable);
    C_TIMEOUT: cover property ($rose(o_rx_timeout));
    C_BACK: cover property (o_busy && o_tx_empty);
endmodule

bind asp_top asp_checker u_chk (.i_clock, .i_reset, .o_ctl, .i_lcr_write, .i_lcr,
    .o_line_cfg, .i_tx_write, .o_tx_full, .o_tx_empty, .o_busy, .o_rx_valid,
    .o_rx_timeout, .o_serial_out);

// ### tb/asp_remote.sv
// Remote serial device: sends frames to the port and decodes its output
module asp_remote
    import asp_pkg::*;
#(
    parameter int BIT_CLKS = 32
)
(
    input wire logic i_clock,
    input wire logic i_line,
    input wire asp_lcr_type i_lcr,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rx_q[$];

    // Idle line rests high, as a pull-up leaves it
    initial o_line = 1'b1;

    function automatic logic pbit(input logic [7:0] d);
        if (i_lcr.stick_parity)
            return !i_lcr.even_parity;
        return ^d ^ !i_lcr.even_parity;
    endfunction

    task automatic drive(input logic b);
        @(posedge i_clock);
        o_line <= b;
        repeat (BIT_CLKS - 1) @(posedge i_clock);
    endtask

    // Short low pulse that must not count as a start
    task automatic glitch();
        @(posedge i_clock);
        o_line <= 1'b0;
        repeat (BIT_CLKS / 4) @(posedge i_clock);
        o_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge i_clock);
    endtask

    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        drive(1'b0);
        for (int i = 0; i < 5 + i_lcr.word_len; i++)
            drive(d[i]);
        if (i_lcr.parity_enable)
            drive(pbit(d) ^ bad_par);
        drive(!bad_stop);
        drive(1'b1);
    endtask

    // Bit 8 of each entry says parity and stop bits were good
    always
    begin
        logic [8:0] v;
        v = 9'h100;
        @(negedge i_line);
        repeat (BIT_CLKS / 2) @(posedge i_clock);
        for (int i = 0; i < 6 + i_lcr.word_len + i_lcr.parity_enable + i_lcr.two_stop; i++)
        begin
            repeat (BIT_CLKS) @(posedge i_clock);
            if (i < 5 + i_lcr.word_len)
                v[i] = i_line;
            else if (i_lcr.parity_enable && i == 5 + i_lcr.word_len)
                v[8] = v[8] & (i_line === pbit(v[7:0]));
            else
                v[8] = v[8] & i_line;
        end
        rx_q.push_back(v);
    end
endmodule

// ### tb/asp_top_tb.sv
// Self-checking bench for the async serial port
module asp_top_tb
    import asp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock, i_reset, i_ctl_write, i_div_int_write, i_div_frac_write, i_lcr_write;
    logic i_tx_write, o_tx_full, o_tx_empty, o_busy, i_rx_pop, o_rx_valid, o_rx_full;
    logic o_rx_timeout, i_serial_in, o_serial_out;
    asp_ctl_type i_ctl, o_ctl;
    asp_lcr_type i_lcr, lcr;
    asp_line_cfg_type o_line_cfg;
    asp_rx_entry_type o_rx_entry;
    logic [DIV_INT_W-1:0] i_div_int;
    logic [DIV_FRAC_W-1:0] i_div_frac;
    logic [7:0] i_ir_lp_divisor, i_tx_data;
    int err_total, num_checks;
    int exp_q[$];

    initial i_clock = 1'b0;
    always #20 i_clock = ~i_clock;

    asp_top i_dut (.i_clock, .i_reset, .i_ctl_write, .i_ctl, .o_ctl, .i_div_int_write,
        .i_div_int, .i_div_frac_write, .i_div_frac, .i_lcr_write, .i_lcr, .o_line_cfg,
        .i_ir_lp_divisor, .i_tx_write, .i_tx_data, .o_tx_full, .o_tx_empty, .o_busy,
        .i_rx_pop, .o_rx_entry, .o_rx_valid, .o_rx_full, .o_rx_timeout, .i_serial_in,
        .o_serial_out);
    asp_remote #(.BIT_CLKS(32)) u_rem (.i_clock, .i_line(o_serial_out), .i_lcr(lcr),
        .o_line(i_serial_in));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_rx(input asp_rx_entry_type exp);
        num_checks++;
        if (o_rx_entry !== exp)
        begin
            err_total++;
            $display("BAD rx entry exp %h got %h", exp, o_rx_entry);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic ctl(input logic en, input logic lb = 1'b0);
        @(posedge i_clock);
        i_ctl_write <= 1'b1;
        i_ctl <= {2'h3, lb, 2'h0, en};
        @(posedge i_clock);
        i_ctl_write <= 1'b0;
    endtask

    task automatic pop();
        @(posedge i_clock);
        i_rx_pop <= 1'b1;
        @(posedge i_clock);
        i_rx_pop <= 1'b0;
    endtask

    // Divisor 2 gives 32 clocks a bit, short enough for many frames
    task automatic cfg(input asp_lcr_type l);
        ctl(1'b0);
        i_div_int_write <= 1'b1;
        i_div_frac_write <= 1'b1;
        @(posedge i_clock);
        i_div_int_write <= 1'b0;
        i_div_frac_write <= 1'b0;
        i_lcr_write <= 1'b1;
        i_lcr <= l;
        lcr <= l;
        @(posedge i_clock);
        i_lcr_write <= 1'b0;
        @(negedge i_clock);
        chk("line config", {2'h0, 16'h0002, 6'h00, l}, o_line_cfg);
    endtask

    task automatic put(input logic [7:0] d, input int depth);
        @(posedge i_clock);
        i_tx_write <= 1'b1;
        i_tx_data <= d;
        if (exp_q.size() < depth)
            exp_q.push_back({1'b1, d & (8'hff >> (3 - lcr.word_len))});
        @(posedge i_clock);
        i_tx_write <= 1'b0;
    endtask

    initial
    begin
        asp_lcr_type l;
        logic [7:0] d;
        logic bp, bs;
        int n;
        {i_ctl_write, i_div_int_write, i_div_frac_write, i_lcr_write, i_tx_write} = '0;
        i_rx_pop = 1'b0;
        i_ctl = CTL_RESET;
        i_lcr = '0;
        lcr = '0;
        i_div_int = 16'h0002;
        i_div_frac = 6'h00;
        i_tx_data = 8'h00;
        i_ir_lp_divisor = 8'h01;
        err_total = 0;
        num_checks = 0;
        i_reset = 1'b1;
        void'($urandom(32'h62cc));
        repeat (10) @(posedge i_clock);
        i_reset <= 1'b0;
        @(negedge i_clock);
        chk("ctl reset", CTL_RESET, o_ctl);
        chk("idle line", 1, o_serial_out);
        for (int k = 0; k < 5; k++)
        begin
            l = '0;
            l.word_len = 2'(k);
            l.parity_enable = k inside {[1:3]};
            l.even_parity = k == 1;
            l.stick_parity = k == 3;
            l.two_stop = k[0];
            l.fifo_enable = k != 4;
            cfg(l);
            n = (k == 0) ? 17 : 3;
            for (int j = 0; j < n; j++)
                put(8'($urandom), l.fifo_enable ? 16 : 1);
            @(negedge i_clock);
            chk("tx full", exp_q.size() == (l.fifo_enable ? 16 : 1), o_tx_full);
            ctl(1'b1);
            n = 0;
            while (o_busy !== 1'b0 && n < 9000)
            begin
                @(posedge i_clock);
                n++;
            end
            repeat (40) @(posedge i_clock);
            chk("busy", 0, o_busy);
            chk("frames", exp_q.size(), u_rem.rx_q.size());
            while (exp_q.size() > 0 && u_rem.rx_q.size() > 0)
                chk("frame", exp_q.pop_front(), u_rem.rx_q.pop_front());
            exp_q.delete();
            d = 8'($urandom) & (8'hff >> (3 - l.word_len));
            d = (k == 3) ? 8'h00 : d;
            bp = l.parity_enable && k != 1;
            bs = k[0];
            u_rem.send(d, bp, bs);
            repeat (1100) @(posedge i_clock);
            chk("rx timeout", 1, o_rx_timeout);
            chk_rx({1'b0, bs && d == 0 && (!l.parity_enable || u_rem.pbit(d) == bp), bp, bs, d});
            pop();
        end
        u_rem.glitch();
        u_rem.send(8'h1a, 1'b0, 1'b0);
        u_rem.send(8'h05, 1'b0, 1'b0);
        @(negedge i_clock);
        chk_rx({4'h0, 8'h1a});
        chk("rx full", 1, o_rx_full);
        pop();
        u_rem.send(8'h0c, 1'b0, 1'b0);
        @(negedge i_clock);
        chk_rx({4'h8, 8'h0c});
        pop();
        // No infrared turnaround, so no 10 ms wait
        ctl(1'b1, 1'b1);
        put(8'h13, 1);
        repeat (400) @(posedge i_clock);
        chk_rx({4'h0, 8'h13});
        summarize();
    end

    // Bound well above the longest expected run of about 15500 cycles
    initial
    begin
        repeat (60000) @(posedge i_clock);
        err_total++;
        summarize();
    end
endmodule
